// ===== hw/cwsd_consts.svh
// Constants for the card I/O write strobe decoder.
// Assumes inclusion by bare name from the design files.
`ifndef CWSD_CONSTS_SVH
`define CWSD_CONSTS_SVH
`define CWSD_DATA_W 16
`define CWSD_ADDR_W 3
`define CWSD_SYNC_STAGES 2
`define CWSD_ROLE_PRIMARY 1'h1
`define CWSD_ROLE_SECONDARY 1'h0
`define CWSD_MODE_MEM 2'h0
`define CWSD_MODE_IO 2'h1
`define CWSD_MODE_IDE 2'h2
`endif

// ===== hw/cwsd_pkg.sv
// Types shared by the write strobe decoder files.
// Assumes the constants header is on the include path.
`include "cwsd_consts.svh"
package cwsd_pkg;
    // Interface operating mode
    typedef enum logic [1:0] {
        CWSD_MEM = `CWSD_MODE_MEM,
        CWSD_IO = `CWSD_MODE_IO,
        CWSD_IDE = `CWSD_MODE_IDE
    } cwsd_mode_e;
    // Captured register write
    typedef struct packed {
        logic [`CWSD_ADDR_W-1:0] addr;
        logic [`CWSD_DATA_W-1:0] data;
    } cwsd_wr_s;
    // Host bus pins after sampling
    typedef struct packed {
        logic io_write_strobe_n;
        logic oe_strobe_n;
        logic device_role_strap_n;
        logic ide_mode_select_n;
    } cwsd_pins_s;
endpackage

// ===== hw/cwsd_sync.sv
// Two-stage synchroniser for a group of host pins.
// Assumes pins are asynchronous to i_sys_clk.
`timescale 1ns/100ps
`default_nettype none
module cwsd_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Pins in, synced out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    // All state in one struct
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } cwsd_sync_s;
    cwsd_sync_s st_q, st_d;
    ////////////////////////////////////////////////////////////////
    // Next state: stage one is read only by stage two
    always_comb begin
        st_d.s1 = i_async;
        st_d.s2 = st_q.s1;
    end
    // Register; reset value is the idle level of the pins it carries,
    // so nothing downstream sees a false edge as reset lets go
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end
    assign o_sync = st_q.s2;
endmodule
`default_nettype wire

// ===== hw/cwsd_top.sv
// Card-side decoder for the host I/O write strobe and device role strap.
// Assumes host pins are asynchronous; controller registers sit downstream.
`timescale 1ns/100ps
`default_nettype none
`include "cwsd_consts.svh"
module cwsd_top #(
    parameter int DATA_W = `CWSD_DATA_W,
    parameter int ADDR_W = `CWSD_ADDR_W
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Host pins (asynchronous)
    input wire logic i_io_write_strobe_n,
    input wire logic i_oe_strobe_n,
    input wire logic i_device_role_strap_n,
    input wire logic i_ide_mode_select_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_data,
    // Mode from card configuration logic
    input wire logic i_io_mode,
    // Burst control from the DMA engine
    input wire logic i_udma_start,
    // Register write port
    output logic o_reg_wr,
    output logic [ADDR_W-1:0] o_reg_addr,
    output logic [DATA_W-1:0] o_reg_data,
    // Read enable to the data path
    output logic o_reg_rd_en,
    // Status
    output logic o_udma_active,
    output logic o_udma_stop,
    output logic o_role_primary,
    output cwsd_pkg::cwsd_mode_e o_mode
);
    import cwsd_pkg::*;
    ////////////////////////////////////////////////////////////////
    // Pin synchroniser: strobes, strap, mode select
    // Pins idle high, so the synchroniser resets to ones; the strobe
    // edge detector fed by it then sees no false edge after reset.
    logic [3:0] pins_raw;
    logic [3:0] pins_syn;
    cwsd_pins_s pins;
    assign pins_raw = {i_io_write_strobe_n, i_oe_strobe_n, i_device_role_strap_n, i_ide_mode_select_n};
    cwsd_sync #(
        .WIDTH(4),
        .RST_VAL(4'hF)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_async(pins_raw),
        .o_sync(pins_syn)
    );
    assign pins = cwsd_pins_s'(pins_syn);
    ////////////////////////////////////////////////////////////////
    // Bus synchroniser: address and data pass the same two stages as
    // the strobe, so the synced bus lines up with the synced strobe and
    // no logic reads a raw pin. Costs a flop pair per bus bit.
    localparam int BUS_W = ADDR_W + DATA_W;
    logic [BUS_W-1:0] bus_raw;   // Address over data, straight from the pins
    logic [BUS_W-1:0] bus_syn;   // Same, two clocks later
    logic [ADDR_W-1:0] bus_addr; // Synced address
    logic [DATA_W-1:0] bus_data; // Synced data
    assign bus_raw = {i_addr, i_data};
    cwsd_sync #(
        .WIDTH(BUS_W),
        .RST_VAL('0)
    ) u_bus_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_async(bus_raw),
        .o_sync(bus_syn)
    );
    assign bus_addr = bus_syn[BUS_W-1:DATA_W];
    assign bus_data = bus_syn[DATA_W-1:0];
    ////////////////////////////////////////////////////////////////
    // The host holds address and data across the strobe, so the synced
    // bus is staged while the synced strobe is low and handed on at its
    // rise; the strobe edge is what matters, not the bus timing.
    typedef struct packed {
        logic strb_prev;     // Previous synced strobe level
        logic [ADDR_W-1:0] addr_hold;
        logic [DATA_W-1:0] data_hold;
        logic wr;            // One-cycle write pulse
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
        logic udma;          // Burst in progress
        logic stop;          // One-cycle stop pulse
        logic role_primary;  // Latched role
        logic role_taken;    // Strap sampled once after reset
        logic [1:0] role_wait; // Clocks since reset, until the strap is synced
        logic stop_tail;     // Host stop still low after the burst ended
        cwsd_mode_e mode;    // Registered operating mode
    } cwsd_top_s;
    cwsd_top_s st_q, st_d;
    // Mode decode from select pin and configuration
    // The select pin wins: a low pin means IDE whatever the config says
    function automatic cwsd_mode_e decode_mode(input logic sel_n, input logic io);
        if (!sel_n) begin
            decode_mode = CWSD_IDE;
        end else if (io) begin
            decode_mode = CWSD_IO;
        end else begin
            decode_mode = CWSD_MEM;
        end
    endfunction
    ////////////////////////////////////////////////////////////////
    // Next-state logic
    // Edges are found on the synced strobe only; a strobe phase shorter
    // than one clock may be missed, which the host timing rules out.
    // Write and stop pulses default low so each lasts one clock.
    always_comb begin
        logic rise;
        logic fall;
        rise = 1'b0;
        fall = 1'b0;
        st_d = st_q;
        st_d.wr = 1'b0;
        st_d.stop = 1'b0;
        st_d.mode = decode_mode(pins.ide_mode_select_n, i_io_mode);
        st_d.strb_prev = pins.io_write_strobe_n;
        rise = pins.io_write_strobe_n & ~st_q.strb_prev;
        fall = ~pins.io_write_strobe_n & st_q.strb_prev;
        // Strap caught once, only after the synchroniser holds the real
        // pin level; before that it still shows its reset ones, which
        // would read as an open strap on every board.
        if (st_q.role_wait != 2'(`CWSD_SYNC_STAGES)) begin
            st_d.role_wait = st_q.role_wait + 2'h1;
        end else if (!st_q.role_taken) begin
            st_d.role_taken = 1'b1;
            st_d.role_primary = pins.device_role_strap_n ? `CWSD_ROLE_SECONDARY
                                                         : `CWSD_ROLE_PRIMARY;
        end
        // Latch synced bus while synced strobe low; valid at the trailing edge
        if (!pins.io_write_strobe_n) begin
            st_d.addr_hold = bus_addr;
            st_d.data_hold = bus_data;
        end
        unique case (st_q.mode)
            CWSD_MEM: begin
                // Strobe has no meaning here; burst state cleared
                st_d.udma = 1'b0;
                st_d.stop_tail = 1'b0;
            end
            CWSD_IO: begin
                st_d.udma = 1'b0;
                st_d.stop_tail = 1'b0;
                if (rise) begin
                    st_d.wr = 1'b1;
                    st_d.wr_addr = st_q.addr_hold;
                    st_d.wr_data = st_q.data_hold;
                end
            end
            CWSD_IDE: begin
                if (st_q.udma) begin
                    // Pin is STOP; asserted host stop ends the burst
                    // Only the falling edge counts; a level would re-end
                    // a burst that was started again too soon
                    if (fall) begin
                        st_d.udma = 1'b0;
                        st_d.stop = 1'b1;
                        st_d.stop_tail = 1'b1;
                    end
                end else begin
                    // Burst may begin only with strobe deasserted
                    if (i_udma_start && pins.io_write_strobe_n) begin
                        st_d.udma = 1'b1;
                        st_d.stop_tail = 1'b0;
                    end else if (rise && st_q.stop_tail) begin
                        // Host releasing its stop after the burst: no register load
                        st_d.stop_tail = 1'b0;
                    end else if (rise) begin
                        st_d.wr = 1'b1;
                        st_d.wr_addr = st_q.addr_hold;
                        st_d.wr_data = st_q.data_hold;
                    end
                end
            end
            default: begin
                // Reserved code: treat as memory mode
                st_d.udma = 1'b0;
                st_d.stop_tail = 1'b0;
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////
    // State register
    // Reset loads constants only; role and mode become valid again a few
    // clocks after release, once the synchronisers have refilled.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= '{strb_prev: 1'b1, addr_hold: '0, data_hold: '0, wr: 1'b0, wr_addr: '0,
                      wr_data: '0, udma: 1'b0, stop: 1'b0, role_primary: 1'b0, role_taken: 1'b0,
                      role_wait: 2'h0, stop_tail: 1'b0, mode: CWSD_MEM};
        end else begin
            st_q <= st_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Outputs: data and status straight from flip-flops; the read enable
    // is a handshake qualifier, so it is gated from synced flops directly
    assign o_reg_wr = st_q.wr;
    assign o_reg_addr = st_q.wr_addr;
    assign o_reg_data = st_q.wr_data;
    assign o_reg_rd_en = ~pins.oe_strobe_n && (st_q.mode != CWSD_MEM) && !st_q.udma;
    assign o_udma_active = st_q.udma;
    assign o_udma_stop = st_q.stop;
    assign o_role_primary = st_q.role_primary;
    assign o_mode = st_q.mode;
endmodule
`default_nettype wire

// ===== testbench/cwsd_sva.sv
// Port checker for the write strobe decoder.
// Assumes a bind into cwsd_top.
`timescale 1ns/100ps
`default_nettype none
module cwsd_sva import cwsd_pkg::*; #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 3
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_io_write_strobe_n,
    input wire logic i_device_role_strap_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_data,
    input wire logic o_reg_wr,
    input wire logic [ADDR_W-1:0] o_reg_addr,
    input wire logic [DATA_W-1:0] o_reg_data,
    input wire logic o_udma_active,
    input wire logic o_udma_stop,
    input wire logic o_role_primary,
    input wire logic [1:0] o_mode
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    // Strap only moves under reset in the bench
    a_role_open: assert property (i_device_role_strap_n |-> !o_role_primary) else $error("open strap");
    a_role_grnd: assert property (o_role_primary |-> !i_device_role_strap_n) else $error("bad primary");
    a_mem_ignore: assert property (o_reg_wr |-> o_mode != CWSD_MEM) else $error("mem write");
    a_io_load: assert property ($rose(i_io_write_strobe_n) && o_mode == CWSD_IO |-> ##[2:5] o_reg_wr)
        else $error("no write");
    // Strobe must have been low before and high after the capture point
    a_trail_edge: assert property (o_reg_wr |-> $past(i_io_write_strobe_n, 2) && !$past(i_io_write_strobe_n, 6))
        else $error("wrong edge");
    a_wr_data: assert property (o_reg_wr |-> o_reg_data == $past(i_data, 2) && o_reg_addr == $past(i_addr, 2))
        else $error("bad data");
    a_stop_prompt: assert property (o_udma_active && $fell(i_io_write_strobe_n) |-> ##[1:4] o_udma_stop)
        else $error("no stop");
    a_stop_ends: assert property (o_udma_stop |-> !o_udma_active && $past(o_udma_active)) else $error("stop");
    a_stop_pulse: assert property (o_udma_stop |=> !o_udma_stop) else $error("long stop");
    a_burst_nowr: assert property (o_reg_wr |-> !$past(o_udma_active)) else $error("write in burst");
    c_ide_wr: cover property (o_reg_wr && o_mode == CWSD_IDE);
    c_stop: cover property (o_udma_stop);
    c_primary: cover property (o_role_primary);
endmodule
bind cwsd_top cwsd_sva #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_cwsd_sva (.i_sys_clk, .i_reset_n,
    .i_io_write_strobe_n, .i_device_role_strap_n, .i_addr, .i_data, .o_reg_wr, .o_reg_addr,
    .o_reg_data, .o_udma_active, .o_udma_stop, .o_role_primary, .o_mode);
`default_nettype wire

// ===== testbench/cwsd_host_model.sv
// Host side model: write strobe, read strobe and bus.
// Assumes the bench calls its tasks.
`timescale 1ns/100ps
`default_nettype none
module cwsd_host_model (
    // Clock
    input wire logic i_sys_clk,
    // Host pins
    output logic o_io_write_strobe_n,
    output logic o_oe_strobe_n,
    output logic [2:0] o_addr,
    output logic [15:0] o_data
);
    initial begin
        o_io_write_strobe_n = 1'h1;
        o_oe_strobe_n = 1'h1;
        o_addr = 3'h0;
        o_data = 16'h0;
    end
    // One write pulse; bus held past the rise, then released
    task automatic wr(input logic [2:0] ad, input logic [15:0] dt, input int lo);
        @(negedge i_sys_clk);
        o_addr = ad;
        o_data = dt;
        o_io_write_strobe_n = 1'h0;
        repeat (lo) @(negedge i_sys_clk);
        o_io_write_strobe_n = 1'h1;
        repeat (6) @(negedge i_sys_clk);
        o_data = ~o_data; // Released bus must not look valid
    endtask
    // Read strobe level, held four cycles
    task automatic oe(input logic v);
        @(negedge i_sys_clk);
        o_oe_strobe_n = v;
        repeat (4) @(negedge i_sys_clk);
    endtask
endmodule
`default_nettype wire

// ===== testbench/card_io_write_strobe_decode_tb_top.sv
// Self-checking bench for the write strobe decoder.
// Assumes the host model drives the bus pins.
`timescale 1ns/100ps
`default_nettype none
module card_io_write_strobe_decode_tb_top;
    import cwsd_pkg::*;
    logic clk = 0, rst_n = 0, strap_n = 1, ide_n = 1, io_mode = 0, udma = 0;
    logic stb_n, oe_n, wr, rd_en, act, stop, prim;
    logic [2:0] a, ra;
    logic [15:0] d, rdat;
    logic [18:0] last;
    cwsd_mode_e mode;
    int failures = 0, n_checks = 0, n_wr = 0, n_stop = 0, c, m;
    integer seed = 32'hF853ED94;
    always #12.5 clk = ~clk;
    cwsd_host_model i_cwsd_host_model (.i_sys_clk(clk), .o_io_write_strobe_n(stb_n), .o_oe_strobe_n(oe_n),
        .o_addr(a), .o_data(d));
    cwsd_top i_cwsd_top (.i_sys_clk(clk), .i_reset_n(rst_n), .i_io_write_strobe_n(stb_n), .i_oe_strobe_n(oe_n),
        .i_device_role_strap_n(strap_n), .i_ide_mode_select_n(ide_n), .i_addr(a), .i_data(d), .i_io_mode(io_mode),
        .i_udma_start(udma), .o_reg_wr(wr), .o_reg_addr(ra), .o_reg_data(rdat), .o_reg_rd_en(rd_en),
        .o_udma_active(act), .o_udma_stop(stop), .o_role_primary(prim), .o_mode(mode));
    // Count write and stop pulses mid-cycle, away from the launching edge
    always @(negedge clk) begin
        if (wr === 1'h1) begin
            n_wr++;
            last = {ra, rdat};
        end
        if (stop === 1'h1) n_stop++;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    function automatic logic wr_ok(input int md);
        return md != 0;
    endfunction
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic rst(input logic s);
        @(negedge clk);
        rst_n = 0;
        strap_n = s;
        repeat (3) @(negedge clk);
        rst_n = 1;
        repeat (5) @(negedge clk);
        chk(prim, !s);
    endtask
    // Random write; low time from the minimum of three upward
    task automatic wr_chk(input logic e);
        logic [2:0] wa;
        logic [15:0] wd;
        c = n_wr;
        wa = $random(seed);
        wd = $random(seed);
        i_cwsd_host_model.wr(wa, wd, 3 + ($random(seed) & 3));
        chk(n_wr - c, e);
        if (e) chk(last, {wa, wd});
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        final_report;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        rst(1'h1);
        for (m = 0; m < 3; m++) begin
            ide_n = (m != 2);
            io_mode = (m == 1) ? 1'h1 : ((m == 2) ? 1'($random(seed)) : 1'h0); // Select pin wins in IDE
            repeat (4) @(negedge clk);
            chk(mode, m);
            i_cwsd_host_model.oe(1'h0);
            chk(rd_en, wr_ok(m));
            i_cwsd_host_model.oe(1'h1);
            repeat (6) wr_chk(wr_ok(m));
            $display("mode test %0d done", m);
        end
        // Burst start with strobe idle, then host stop
        udma = 1;
        @(negedge clk);
        udma = 0;
        @(negedge clk);
        chk(act, 1'h1);
        i_cwsd_host_model.oe(1'h0);
        chk(rd_en, 1'h0);
        i_cwsd_host_model.oe(1'h1);
        c = n_stop;
        m = n_wr;
        i_cwsd_host_model.wr(3'h7, 16'hFFFF, 3);
        chk(n_stop - c, 1);
        chk(n_wr - m, 0);
        chk(act, 1'h0);
        wr_chk(1'h1);
        $display("burst test done");
        rst(1'h0);
        wr_chk(1'h1);
        $display("reset test done");
        final_report;
    end
endmodule
`default_nettype wire
